// [core/vadc_pkg.sv]
// Package with register map, field layout, timing and carrier types for the voltage converter sequencer
package vadc_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Register offsets
	localparam logic [7:0] ADDR_READING_2V5 = 8'h20;
	localparam logic [7:0] ADDR_READING_SUPPLY = 8'h21;
	localparam logic [7:0] ADDR_CONFIG_ONE = 8'h40;
	localparam logic [7:0] ADDR_STATUS = 8'h41;
	localparam logic [7:0] ADDR_LOW_LIMIT_2V5 = 8'h44;
	localparam logic [7:0] ADDR_HIGH_LIMIT_2V5 = 8'h45;
	localparam logic [7:0] ADDR_FAN1_MIN_HIGH = 8'h55;
	localparam logic [7:0] ADDR_CONFIG_TWO = 8'h73;

	////////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [7:0] RST_READING = 8'h00;
	localparam logic [7:0] RST_CONFIG_ONE = 8'h00;
	localparam logic [7:0] RST_LOW_LIMIT = 8'h00;
	localparam logic [7:0] RST_HIGH_LIMIT = 8'hff;
	localparam logic [7:0] RST_FAN1_MIN_HIGH = 8'h00;
	localparam logic [7:0] RST_CONFIG_TWO = 8'h00;
	localparam logic [7:0] RST_STATUS = 8'h00;

	////////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int unsigned BIT_SUPPLY_FIVE_VOLT = 7;
	localparam int unsigned BIT_AVERAGING_OFF = 4;
	localparam int unsigned BIT_ATTEN_BYPASS = 5;
	localparam int unsigned BIT_SINGLE_CHANNEL = 6;
	localparam int unsigned CHAN_SEL_MSB = 7;
	localparam int unsigned CHAN_SEL_LSB = 5;
	localparam int unsigned BIT_STATUS_LOW = 0;
	localparam int unsigned BIT_STATUS_HIGH = 1;

	////////////////////////////////////////////////////////////////////////////
	// Converter
	localparam int unsigned CODE_WIDTH = 10;
	localparam logic [9:0] CODE_NOMINAL = 10'h300;
	localparam int unsigned AVG_LOG2 = 4;
	localparam logic [3:0] AVG_LAST = 4'hf;
	localparam logic [2:0] CHAN_INPUT_2V5 = 3'h0;
	localparam logic [2:0] CHAN_SUPPLY = 3'h2;

	////////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned CONV_TIME_NS = 711000;
	localparam int unsigned MEAS_TIME_NS = 11380000;
	localparam int unsigned CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;

	////////////////////////////////////////////////////////////////////////////
	// Carriers
	typedef struct packed {
		logic valid;
		logic first;
		logic [7:0] data;
	} host_wr_t;

	typedef struct packed {
		logic start;
		logic [2:0] muxSel;
		logic attenBypass;
		logic supplyFiveVolt;
	} adc_ctrl_t;

	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_CONVERT = 2'b01,
		SEQ_STORE = 2'b11
	} seq_state_t;

endpackage : vadc_pkg

// [core/avg_accum.sv]
// Accumulator that sums converter samples for averaging
`timescale 1ns/1ps
`default_nettype none

module avg_accum #(
	parameter int unsigned W = 10,
	parameter int unsigned N_LOG2 = 4
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Control
	input wire logic clear,
	input wire logic addEn,
	input wire logic [W-1:0] sample,
	// Result
	output logic [W+N_LOG2-1:0] sum
);

	logic [W+N_LOG2-1:0] sum_q;
	logic [W+N_LOG2-1:0] sum_d;
	logic [W+N_LOG2-1:0] base;

	// Clear and add in one cycle restarts the sum with this sample
	assign base = clear ? '0 : sum_q;
	assign sum_d = addEn ? base + {{N_LOG2{1'b0}}, sample} : base;
	assign sum = sum_d;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sum_q <= '0;
		end else begin
			sum_q <= sum_d;
		end
	end

endmodule : avg_accum

`default_nettype wire

// [core/voltage_adc_sequencer.sv]
// Sequencer, averaging, 2.5 V limit check and register file for the voltage converter channels
`timescale 1ns/1ps
`default_nettype none

module voltage_adc_sequencer #(
	parameter int unsigned CONV_CYCLES = vadc_pkg::CONV_CYCLES
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Host register port, bytes after the serial front end
	input wire vadc_pkg::host_wr_t hostWr,
	input wire logic rdStrobe,
	output logic [7:0] rdData,
	output logic rdValid,
	// Converter macro
	input wire logic [9:0] adcCode,
	output vadc_pkg::adc_ctrl_t adcCtrl,
	// Open-drain alert, enable high pulls the line low
	output logic alertOe
);

	////////////////////////////////////////////////////////////////////////////
	// Declarations
	logic [9:0] codeMeta_q;
	logic [9:0] codeSync_q;
	logic [7:0] pointer_q;
	logic [7:0] pointer_d;
	logic [7:0] reading2v5_q;
	logic [7:0] reading2v5_d;
	logic [7:0] readingSupply_q;
	logic [7:0] readingSupply_d;
	logic [7:0] configOne_q;
	logic [7:0] configOne_d;
	logic [7:0] configTwo_q;
	logic [7:0] configTwo_d;
	logic [7:0] lowLimit_q;
	logic [7:0] lowLimit_d;
	logic [7:0] highLimit_q;
	logic [7:0] highLimit_d;
	logic [7:0] fanMinHigh_q;
	logic [7:0] fanMinHigh_d;
	logic [7:0] status_q;
	logic [7:0] status_d;
	logic [7:0] rdData_q;
	logic [7:0] rdData_d;
	logic rdValid_q;
	logic alert_q;
	logic alert_d;
	logic violation_q;
	logic violation_d;
	vadc_pkg::seq_state_t state_q;
	vadc_pkg::seq_state_t state_d;
	logic [12:0] convCnt_q;
	logic [12:0] convCnt_d;
	logic [3:0] sampleCnt_q;
	logic [3:0] sampleCnt_d;
	logic [2:0] chan_q;
	logic [2:0] chan_d;
	vadc_pkg::adc_ctrl_t adcCtrl_q;
	vadc_pkg::adc_ctrl_t adcCtrl_d;
	logic [13:0] accumSum;

	////////////////////////////////////////////////////////////////////////////
	// Host write decode
	logic wrPointer;
	logic wrData;
	logic wrConfigOne;
	logic wrConfigTwo;
	logic wrLowLimit;
	logic wrHighLimit;
	logic wrFanMinHigh;

	assign wrPointer = hostWr.valid & hostWr.first;
	assign wrData = hostWr.valid & ~hostWr.first;
	assign wrConfigOne = wrData & (pointer_q == vadc_pkg::ADDR_CONFIG_ONE);
	assign wrConfigTwo = wrData & (pointer_q == vadc_pkg::ADDR_CONFIG_TWO);
	assign wrLowLimit = wrData & (pointer_q == vadc_pkg::ADDR_LOW_LIMIT_2V5);
	assign wrHighLimit = wrData & (pointer_q == vadc_pkg::ADDR_HIGH_LIMIT_2V5);
	assign wrFanMinHigh = wrData & (pointer_q == vadc_pkg::ADDR_FAN1_MIN_HIGH);

	assign pointer_d = wrPointer ? hostWr.data : pointer_q;
	assign configOne_d = wrConfigOne ? hostWr.data : configOne_q;
	assign configTwo_d = wrConfigTwo ? hostWr.data : configTwo_q;
	assign lowLimit_d = wrLowLimit ? hostWr.data : lowLimit_q;
	assign highLimit_d = wrHighLimit ? hostWr.data : highLimit_q;
	assign fanMinHigh_d = wrFanMinHigh ? hostWr.data : fanMinHigh_q;

	////////////////////////////////////////////////////////////////////////////
	// Configuration fields
	logic averagingOff;
	logic attenBypass;
	logic singleChannel;
	logic supplyFiveVolt;
	logic [2:0] chanRequest;
	logic [2:0] singleChan;

	assign averagingOff = configTwo_q[vadc_pkg::BIT_AVERAGING_OFF];
	assign attenBypass = configTwo_q[vadc_pkg::BIT_ATTEN_BYPASS];
	assign singleChannel = configTwo_q[vadc_pkg::BIT_SINGLE_CHANNEL];
	assign supplyFiveVolt = configOne_q[vadc_pkg::BIT_SUPPLY_FIVE_VOLT];
	assign chanRequest = fanMinHigh_q[vadc_pkg::CHAN_SEL_MSB:vadc_pkg::CHAN_SEL_LSB];
	// Unlisted codes fall back to the 2.5 V input so the mux never floats
	assign singleChan = (chanRequest == vadc_pkg::CHAN_SUPPLY) ? vadc_pkg::CHAN_SUPPLY
		: vadc_pkg::CHAN_INPUT_2V5;

	////////////////////////////////////////////////////////////////////////////
	// Converter code capture
	// Code is held steady by the macro at sample time, so a plain two-stage capture is safe
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			codeMeta_q <= '0;
			codeSync_q <= '0;
		end else begin
			codeMeta_q <= adcCode;
			codeSync_q <= codeMeta_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Conversion sequencer
	logic convEnd;
	logic sampleTake;
	logic lastSample;
	logic [2:0] nextChan;

	assign convEnd = (state_q == vadc_pkg::SEQ_CONVERT) && (convCnt_q == 13'(CONV_CYCLES - 1));
	assign sampleTake = convEnd;
	// Averaging off stores every conversion, sixteen times faster
	assign lastSample = averagingOff | (sampleCnt_q == vadc_pkg::AVG_LAST);
	// Free-running mode alternates the two voltage channels through one mux
	assign nextChan = singleChannel ? singleChan
		: ((chan_q == vadc_pkg::CHAN_INPUT_2V5) ? vadc_pkg::CHAN_SUPPLY
		: vadc_pkg::CHAN_INPUT_2V5);

	always_comb begin
		state_d = state_q;
		convCnt_d = convCnt_q;
		sampleCnt_d = sampleCnt_q;
		chan_d = chan_q;
		unique case (state_q)
			vadc_pkg::SEQ_IDLE: begin
				state_d = vadc_pkg::SEQ_CONVERT;
				convCnt_d = '0;
				sampleCnt_d = '0;
				chan_d = singleChannel ? singleChan : vadc_pkg::CHAN_INPUT_2V5;
			end
			vadc_pkg::SEQ_CONVERT: begin
				if (convEnd) begin
					convCnt_d = '0;
					if (lastSample) begin
						state_d = vadc_pkg::SEQ_STORE;
					end else begin
						sampleCnt_d = sampleCnt_q + 4'h1;
					end
				end else begin
					convCnt_d = convCnt_q + 13'h1;
				end
			end
			vadc_pkg::SEQ_STORE: begin
				state_d = vadc_pkg::SEQ_CONVERT;
				sampleCnt_d = '0;
				chan_d = nextChan;
			end
			default: begin
				state_d = vadc_pkg::SEQ_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Averaging
	logic accumClear;
	logic [9:0] averageCode;
	logic [9:0] resultCode;

	assign accumClear = (sampleCnt_q == 4'h0);

	avg_accum #(
		.W(vadc_pkg::CODE_WIDTH),
		.N_LOG2(vadc_pkg::AVG_LOG2)
	) u_accum (
		.clk_sys(clk_sys),
		.rst(rst),
		.clear(accumClear),
		.addEn(sampleTake),
		.sample(codeSync_q),
		.sum(accumSum)
	);

	// Sum of sixteen 10-bit codes cannot wrap, so the mean stays in 0..1023
	assign averageCode = accumSum[13:4];
	assign resultCode = averagingOff ? codeSync_q : averageCode;

	////////////////////////////////////////////////////////////////////////////
	// Reading update and limit compare
	logic storeNow;
	logic store2v5;
	logic storeSupply;
	logic [7:0] newReading;
	logic lowFault;
	logic highFault;
	logic [7:0] statusSet;
	logic statusRead;
	logic [7:0] statusClr;

	// Result latched in the cycle after the last sample, while the sum is still held
	assign storeNow = (state_q == vadc_pkg::SEQ_STORE);
	assign store2v5 = storeNow & (chan_q == vadc_pkg::CHAN_INPUT_2V5);
	assign storeSupply = storeNow & (chan_q == vadc_pkg::CHAN_SUPPLY);
	assign newReading = resultCode[9:2];

	assign reading2v5_d = store2v5 ? newReading : reading2v5_q;
	assign readingSupply_d = storeSupply ? newReading : readingSupply_q;

	assign lowFault = newReading < lowLimit_q;
	assign highFault = newReading > highLimit_q;

	always_comb begin
		statusSet = '0;
		statusSet[vadc_pkg::BIT_STATUS_LOW] = store2v5 & lowFault;
		statusSet[vadc_pkg::BIT_STATUS_HIGH] = store2v5 & highFault;
	end

	assign statusRead = rdStrobe & (pointer_q == vadc_pkg::ADDR_STATUS);
	assign statusClr = statusRead ? 8'hff : 8'h00;
	// A violation in the read cycle survives the clear
	assign status_d = (status_q & ~statusClr) | statusSet;

	// Live condition follows each new 2.5 V reading
	assign violation_d = store2v5 ? (lowFault | highFault) : violation_q;

	// Alert drops only on a status read with the condition gone
	assign alert_d = (|statusSet) | (alert_q & ~(statusRead & ~violation_q));

	////////////////////////////////////////////////////////////////////////////
	// Converter control outputs
	always_comb begin
		adcCtrl_d.start = (state_q == vadc_pkg::SEQ_CONVERT) && (convCnt_q == 13'h0);
		adcCtrl_d.muxSel = chan_q;
		// Attenuator engaged by default so nominal input lands near CODE_NOMINAL
		adcCtrl_d.attenBypass = attenBypass;
		adcCtrl_d.supplyFiveVolt = supplyFiveVolt;
	end

	////////////////////////////////////////////////////////////////////////////
	// Register read
	logic [7:0] rdMux;

	always_comb begin
		unique case (pointer_q)
			vadc_pkg::ADDR_READING_2V5: rdMux = reading2v5_q;
			vadc_pkg::ADDR_READING_SUPPLY: rdMux = readingSupply_q;
			vadc_pkg::ADDR_CONFIG_ONE: rdMux = configOne_q;
			vadc_pkg::ADDR_STATUS: rdMux = status_q;
			vadc_pkg::ADDR_LOW_LIMIT_2V5: rdMux = lowLimit_q;
			vadc_pkg::ADDR_HIGH_LIMIT_2V5: rdMux = highLimit_q;
			vadc_pkg::ADDR_FAN1_MIN_HIGH: rdMux = fanMinHigh_q;
			vadc_pkg::ADDR_CONFIG_TWO: rdMux = configTwo_q;
			default: rdMux = 8'h00;
		endcase
	end

	assign rdData_d = rdStrobe ? rdMux : rdData_q;

	////////////////////////////////////////////////////////////////////////////
	// State registers
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pointer_q <= 8'h00;
			configOne_q <= vadc_pkg::RST_CONFIG_ONE;
			configTwo_q <= vadc_pkg::RST_CONFIG_TWO;
			lowLimit_q <= vadc_pkg::RST_LOW_LIMIT;
			highLimit_q <= vadc_pkg::RST_HIGH_LIMIT;
			fanMinHigh_q <= vadc_pkg::RST_FAN1_MIN_HIGH;
			reading2v5_q <= vadc_pkg::RST_READING;
			readingSupply_q <= vadc_pkg::RST_READING;
			status_q <= vadc_pkg::RST_STATUS;
			violation_q <= 1'b0;
			alert_q <= 1'b0;
		end else begin
			pointer_q <= pointer_d;
			configOne_q <= configOne_d;
			configTwo_q <= configTwo_d;
			lowLimit_q <= lowLimit_d;
			highLimit_q <= highLimit_d;
			fanMinHigh_q <= fanMinHigh_d;
			reading2v5_q <= reading2v5_d;
			readingSupply_q <= readingSupply_d;
			status_q <= status_d;
			violation_q <= violation_d;
			alert_q <= alert_d;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_q <= vadc_pkg::SEQ_IDLE;
			convCnt_q <= '0;
			sampleCnt_q <= '0;
			chan_q <= vadc_pkg::CHAN_INPUT_2V5;
			adcCtrl_q <= '0;
			rdData_q <= 8'h00;
			rdValid_q <= 1'b0;
		end else begin
			state_q <= state_d;
			convCnt_q <= convCnt_d;
			sampleCnt_q <= sampleCnt_d;
			chan_q <= chan_d;
			adcCtrl_q <= adcCtrl_d;
			rdData_q <= rdData_d;
			rdValid_q <= rdStrobe;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign rdData = rdData_q;
	assign rdValid = rdValid_q;
	assign adcCtrl = adcCtrl_q;
	assign alertOe = alert_q;

endmodule : voltage_adc_sequencer

`default_nettype wire

// [verification/voltage_adc_sequencer_asserts.sv]
// Port timing checker for the voltage converter sequencer
`timescale 1ns/1ps
`default_nettype none

module voltage_adc_sequencer_asserts #(
	parameter int unsigned CONV_CYCLES = 8
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Host side
	input wire vadc_pkg::host_wr_t hostWr,
	input wire logic rdStrobe,
	input wire logic [7:0] rdData,
	input wire logic rdValid,
	// Converter side
	input wire logic [9:0] adcCode,
	input wire vadc_pkg::adc_ctrl_t adcCtrl,
	input wire logic alertOe
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);

	////////////////////////////////////////////////////////////////////////////
	// Mirror of the pointer, so writes can be attributed
	logic [7:0] ptr_q;
	logic [15:0] gap_q;
	logic seen_q;
	logic stRd1_q;
	logic stRd2_q;
	wire logic dataWr = hostWr.valid && !hostWr.first;
	wire logic statRd = rdStrobe && (ptr_q == vadc_pkg::ADDR_STATUS);
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ptr_q <= 8'h00;
			seen_q <= 1'b0;
		end else begin
			ptr_q <= (hostWr.valid && hostWr.first) ? hostWr.data : ptr_q;
			seen_q <= seen_q | adcCtrl.start;
		end
		gap_q <= adcCtrl.start ? 16'h0001 : gap_q + 16'h0001;
		stRd1_q <= statRd;
		stRd2_q <= stRd1_q;
	end

	////////////////////////////////////////////////////////////////////////////
	start_pulse_a: assert property (adcCtrl.start |=> !adcCtrl.start)
		else $error("start longer than one cycle");
	start_gap_a: assert property (adcCtrl.start && seen_q |->
		(gap_q == 16'(CONV_CYCLES)) || (gap_q == 16'(CONV_CYCLES + 1)))
		else $error("start spacing wrong");
	mux_hold_a: assert property (adcCtrl.start |=> $stable(adcCtrl.muxSel) [*6])
		else $error("mux moved inside window");
	rd_answer_a: assert property (rdStrobe |=> rdValid)
		else $error("read not answered");
	rd_lone_a: assert property (rdValid |-> $past(rdStrobe))
		else $error("unrequested read valid");
	rd_hold_a: assert property (!rdStrobe |=> $stable(rdData))
		else $error("read data moved");
	atten_ctrl_a: assert property (dataWr && ptr_q == vadc_pkg::ADDR_CONFIG_TWO |->
		##2 adcCtrl.attenBypass == $past(hostWr.data[5], 2))
		else $error("bypass not following config");
	five_volt_a: assert property (dataWr && ptr_q == vadc_pkg::ADDR_CONFIG_ONE |->
		##2 adcCtrl.supplyFiveVolt == $past(hostWr.data[7], 2))
		else $error("supply scaling not following config");
	alert_clear_a: assert property ($fell(alertOe) |-> stRd1_q || stRd2_q)
		else $error("alert released without status read");
	alert_status_a: assert property (stRd1_q && rdValid &&
		(rdData[vadc_pkg::BIT_STATUS_LOW] || rdData[vadc_pkg::BIT_STATUS_HIGH]) |-> $past(alertOe))
		else $error("status fault without alert");
endmodule : voltage_adc_sequencer_asserts

bind voltage_adc_sequencer voltage_adc_sequencer_asserts #(.CONV_CYCLES(CONV_CYCLES))
	voltage_adc_sequencer_asserts_i (.clk_sys(clk_sys), .rst(rst), .hostWr(hostWr), .rdStrobe(rdStrobe),
	.rdData(rdData), .rdValid(rdValid), .adcCode(adcCode), .adcCtrl(adcCtrl), .alertOe(alertOe));

`default_nettype wire

// [verification/adc_macro_model.sv]
// Behavioural converter macro returning a preset code per channel
`timescale 1ns/1ps
`default_nettype none

module adc_macro_model (
	// Clock
	input wire logic clk_sys,
	// Control from the sequencer
	input wire vadc_pkg::adc_ctrl_t adcCtrl,
	// Preset codes
	input wire logic [9:0] codeIn,
	input wire logic [9:0] codeSupply,
	// Result
	output logic [9:0] adcCode
);
	initial adcCode = 10'h000;
	// Latched at start so the result stays still through the window
	always @(posedge clk_sys) begin
		if (adcCtrl.start) begin
			adcCode <= (adcCtrl.muxSel == vadc_pkg::CHAN_SUPPLY) ? codeSupply : codeIn;
		end
	end
endmodule : adc_macro_model

`default_nettype wire

// [verification/voltage_adc_sequencer_tb.sv]
// Self-checking bench for the voltage converter sequencer
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin err_total++; \
	$display("[ERR] %s exp %h got %h", nm, e, g); end end

module voltage_adc_sequencer_tb;
	logic clk_sys = 1'b0;
	logic rst;
	vadc_pkg::host_wr_t hostWr;
	logic rdStrobe;
	logic [7:0] rdData;
	logic rdValid;
	logic [9:0] adcCode;
	vadc_pkg::adc_ctrl_t adcCtrl;
	logic alertOe;
	logic [9:0] codeIn;
	logic [9:0] codeSupply;
	int err_total = 0;
	int checked = 0;
	logic [2:0] lastMux;
	int starts;
	int cycles;
	// Short window keeps the run small
	localparam int unsigned SHORT_WINDOW = 8;

	always #50 clk_sys = ~clk_sys;

	voltage_adc_sequencer #(.CONV_CYCLES(SHORT_WINDOW)) voltage_adc_sequencer_i (.clk_sys(clk_sys), .rst(rst),
		.hostWr(hostWr), .rdStrobe(rdStrobe), .rdData(rdData), .rdValid(rdValid), .adcCode(adcCode),
		.adcCtrl(adcCtrl), .alertOe(alertOe));
	adc_macro_model adc_macro_model_i (.clk_sys(clk_sys), .adcCtrl(adcCtrl), .codeIn(codeIn),
		.codeSupply(codeSupply), .adcCode(adcCode));

	////////////////////////////////////////////////////////////////////////////
	task automatic waitc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask : waitc

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		hostWr = '{1'b1, 1'b1, a};
		@(negedge clk_sys);
		hostWr = '{1'b1, 1'b0, d};
		@(negedge clk_sys);
		hostWr = '0;
	endtask : wr

	// Pointer-only write, then read
	task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] e);
		@(negedge clk_sys);
		hostWr = '{1'b1, 1'b1, a};
		@(negedge clk_sys);
		hostWr = '0;
		rdStrobe = 1'b1;
		@(negedge clk_sys);
		rdStrobe = 1'b0;
		`CHK("rdValid", 1'b1, rdValid)
		`CHK(nm, e, rdData)
	endtask : rdc

	task automatic wrap_up();
		$display("checked %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : wrap_up

	////////////////////////////////////////////////////////////////////////////
	initial begin
		#500000;
		err_total++;
		wrap_up();
	end

	initial begin
		hostWr = '0;
		rdStrobe = 1'b0;
		codeIn = 10'h000;
		codeSupply = 10'h000;
		rst = 1'b1;
		waitc(20);
		rst = 1'b0;
		rdc("reading", vadc_pkg::ADDR_READING_2V5, 8'h00);
		rdc("lowLimit", vadc_pkg::ADDR_LOW_LIMIT_2V5, 8'h00);
		rdc("highLimit", vadc_pkg::ADDR_HIGH_LIMIT_2V5, 8'hff);
		wr(vadc_pkg::ADDR_READING_2V5, 8'h55);
		wr(8'h10, 8'h5a);
		rdc("readOnly", vadc_pkg::ADDR_READING_2V5, 8'h00);
		rdc("unmapped", 8'h10, 8'h00);
		wr(vadc_pkg::ADDR_LOW_LIMIT_2V5, 8'h12);
		rdc("lowWrite", vadc_pkg::ADDR_LOW_LIMIT_2V5, 8'h12);
		wr(vadc_pkg::ADDR_LOW_LIMIT_2V5, 8'h00);
		$display("test access done");
		codeIn = 10'h3ff;
		codeSupply = 10'h2a8;
		wr(vadc_pkg::ADDR_CONFIG_TWO, 8'h70);
		wr(vadc_pkg::ADDR_FAN1_MIN_HIGH, 8'h40);
		waitc(40);
		`CHK("muxSupply", vadc_pkg::CHAN_SUPPLY, adcCtrl.muxSel)
		`CHK("bypassOn", 1'b1, adcCtrl.attenBypass)
		rdc("singleSupply", vadc_pkg::ADDR_READING_SUPPLY, 8'haa);
		wr(vadc_pkg::ADDR_FAN1_MIN_HIGH, 8'h00);
		waitc(40);
		`CHK("muxInput", vadc_pkg::CHAN_INPUT_2V5, adcCtrl.muxSel)
		rdc("fullScale", vadc_pkg::ADDR_READING_2V5, 8'hff);
		codeIn = 10'h004;
		waitc(40);
		rdc("fastReading", vadc_pkg::ADDR_READING_2V5, 8'h01);
		$display("test single channel done");
		codeIn = vadc_pkg::CODE_NOMINAL;
		wr(vadc_pkg::ADDR_HIGH_LIMIT_2V5, 8'h80);
		waitc(40);
		`CHK("alertSet", 1'b1, alertOe)
		rdc("highFault", vadc_pkg::ADDR_STATUS, 8'h02);
		`CHK("alertHeld", 1'b1, alertOe)
		// Fault still present, so status is set again before the limit moves
		waitc(20);
		wr(vadc_pkg::ADDR_HIGH_LIMIT_2V5, 8'hff);
		waitc(40);
		`CHK("alertWait", 1'b1, alertOe)
		rdc("sticky", vadc_pkg::ADDR_STATUS, 8'h02);
		waitc(2);
		`CHK("alertFree", 1'b0, alertOe)
		rdc("inRange", vadc_pkg::ADDR_STATUS, 8'h00);
		wr(vadc_pkg::ADDR_LOW_LIMIT_2V5, 8'hd0);
		waitc(40);
		rdc("lowFault", vadc_pkg::ADDR_STATUS, 8'h01);
		wr(vadc_pkg::ADDR_LOW_LIMIT_2V5, 8'h00);
		$display("test limits done");
		codeSupply = 10'h1fc;
		wr(vadc_pkg::ADDR_CONFIG_TWO, 8'h00);
		wr(vadc_pkg::ADDR_CONFIG_ONE, 8'h80);
		waitc(700);
		rdc("avgNominal", vadc_pkg::ADDR_READING_2V5, 8'hc0);
		rdc("avgSupply", vadc_pkg::ADDR_READING_SUPPLY, 8'h7f);
		`CHK("fiveVolt", 1'b1, adcCtrl.supplyFiveVolt)
		`CHK("bypassOff", 1'b0, adcCtrl.attenBypass)
		// Constant codes hide the averaging, so time one whole reading between mux changes
		lastMux = adcCtrl.muxSel;
		while (adcCtrl.muxSel == lastMux) begin
			@(negedge clk_sys);
		end
		lastMux = adcCtrl.muxSel;
		starts = 0;
		cycles = 0;
		while (adcCtrl.muxSel == lastMux) begin
			starts += adcCtrl.start;
			cycles++;
			@(negedge clk_sys);
		end
		`CHK("startsPerReading", 1 << vadc_pkg::AVG_LOG2, starts)
		`CHK("cyclesPerReading", (1 << vadc_pkg::AVG_LOG2) * SHORT_WINDOW + 1, cycles)
		$display("test averaging done");
		wrap_up();
	end
endmodule : voltage_adc_sequencer_tb

`default_nettype wire
